// ===== design/exec_defs.svh
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH

// Register byte offsets on the Avalon-MM slave
`define REG_CTRL_OFS        4'h0
`define REG_WORK_OFS        4'h4
`define REG_FLAGS_OFS       4'h8
`define REG_STATUS_OFS      4'hC

// Control register fields and reset value
`define CTRL_ENABLE_BIT     0
`define CTRL_RESET_VAL      1'b1

// Status flag positions inside the flags register
`define FLAG_CARRY_BIT      0
`define FLAG_HALF_BIT       1
`define FLAG_ZERO_BIT       2
`define FLAG_RANGE_BIT      3
`define FLAGS_RESET_VAL     4'h0

// Status register fields
`define STAT_BUSY_BIT       0
`define STAT_SKIP_BIT       1

// Datapath constants
`define WORK_RESET_VAL      8'h00
`define ALL_ONES            8'hFF
`define SINGLE_BIT          8'h01
`define DEC_STEP            8'h01
`define BYTE_ZERO           8'h00

// Reference clocks per instruction cycle
`define INSTR_CYCLE_CLOCKS  4

`endif

// ===== design/exec_pkg.sv
package exec_pkg;

    // Operations handled by this execution slice
    typedef enum logic [2:0] {
        OP_ROTATE_CARRY_W,
        OP_SUB_BORROW_W,
        OP_SUB_BORROW_M,
        OP_DEC_SKIP_M,
        OP_DEC_SKIP_W,
        OP_SET_BYTE,
        OP_SET_BIT
    } op_t;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC,
        ST_DUMMY
    } state_t;

endpackage

// ===== design/sub_borrow_unit.sv
`timescale 1ns/1ns
`include "exec_defs.svh"

module sub_borrow_unit
(
    input  wire logic [7:0] minuend,     // Working register value
    input  wire logic [7:0] subtrahend,  // Memory operand
    input  wire logic       carryIn,     // Current carry, low means borrow pending
    output logic      [7:0] result,      // Difference
    output logic            carryOut,    // High when result not negative
    output logic            halfOut,     // High when no borrow out of low nibble
    output logic            zeroOut,     // High when result is zero
    output logic            rangeOut     // Signed range exceeded
);
    import exec_pkg::*;

    logic [8:0] wide;
    logic [4:0] nib;
    logic       borrowIn;

    // Borrow is the complement of carry, kept in one place for both forms
    always_comb
    begin
        borrowIn = ~carryIn;
        wide     = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrowIn};
        nib      = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrowIn};
        result   = wide[7:0];
        carryOut = ~wide[8];
        halfOut  = ~nib[4];
        zeroOut  = (wide[7:0] == `BYTE_ZERO);
        rangeOut = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ wide[7]);
    end

endmodule

// ===== design/avalon_regs.sv
`timescale 1ns/1ns
`include "exec_defs.svh"

module avalon_regs
(
    input  wire logic        ref_clk,      // Core clock
    input  wire logic        rst,          // Async reset, active high
    input  wire logic [3:0]  address,      // Byte address
    input  wire logic        read,         // Read request
    input  wire logic        write,        // Write request
    input  wire logic [31:0] writedata,    // Write data
    input  wire logic [3:0]  byteenable,   // Byte lanes
    output logic      [31:0] readdata,     // Read data, valid with waitrequest low
    output logic             waitrequest,  // Stall, one cycle per access
    input  wire logic [7:0]  work,         // Working register to read back
    input  wire logic [3:0]  flags,        // Status flags to read back
    input  wire logic        busy,         // Sequencer busy
    input  wire logic        lastSkip,     // Last decrement requested a skip
    output logic             ctrlEnable,   // Operation acceptance enable
    output logic             workWr,       // One-cycle write strobe for work
    output logic             flagsWr,      // One-cycle write strobe for flags
    output logic      [7:0]  wrByte        // Byte written by software
);
    import exec_pkg::*;

    logic        ack;
    logic        next_ack;
    logic        next_ctrlEnable;
    logic [31:0] next_readdata;
    logic        lane0Write;

    // Every access stalls one cycle so read data comes from a flop
    assign waitrequest = (read | write) & ~ack;
    assign lane0Write  = write & ack & byteenable[0];
    assign workWr      = lane0Write & (address == `REG_WORK_OFS);
    assign flagsWr     = lane0Write & (address == `REG_FLAGS_OFS);
    assign wrByte      = writedata[7:0];

    // Decode; unmapped reads return zero, unmapped writes are dropped
    always_comb
    begin
        next_ack        = (read | write) & ~ack;
        next_ctrlEnable = ctrlEnable;
        next_readdata   = readdata;
        if (lane0Write && address == `REG_CTRL_OFS)
            next_ctrlEnable = writedata[`CTRL_ENABLE_BIT];
        if (read && !ack)
        begin
            next_readdata = 32'h0000_0000;
            case (address)
                `REG_CTRL_OFS:   next_readdata[`CTRL_ENABLE_BIT] = ctrlEnable;
                `REG_WORK_OFS:   next_readdata[7:0] = work;
                `REG_FLAGS_OFS:  next_readdata[3:0] = flags;
                `REG_STATUS_OFS:
                begin
                    next_readdata[`STAT_BUSY_BIT] = busy;
                    next_readdata[`STAT_SKIP_BIT] = lastSkip;
                end
                default:         next_readdata = 32'h0000_0000;
            endcase
        end
    end

    // Register stage
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ack        <= 1'b0;
            ctrlEnable <= `CTRL_RESET_VAL;
            readdata   <= 32'h0000_0000;
        end
        else
        begin
            ack        <= next_ack;
            ctrlEnable <= next_ctrlEnable;
            readdata   <= next_readdata;
        end
    end

endmodule

// ===== design/mcu_rotate_subtract_skip_set_exec.sv
// Operation
// - Rotate-through-carry: work gets {old carry, mem[7:1]}, carry gets mem[0].
// - Rotate-through-carry writes only work; memory unchanged; only carry changes.
// - Subtract-with-borrow to work: work minus mem minus not-carry, flags updated.
// - After subtract-with-borrow, carry is 0 if negative, else 1.
// - Subtract-with-borrow to memory: same difference written back to memory.
// - Decrement-skip: memory byte minus one written back; skip if zero.
// - Non-zero decrement result gives no skip, execution continues normally.
// - Each decrement-skip form takes two instruction cycles, second one dummy.
// - Decrement-to-work: work gets mem minus one, memory untouched, skip if zero.
// - Whole-byte set writes all ones into the memory byte.
// - Single-bit set forces only the selected bit to one.
`timescale 1ns/1ns
`include "exec_defs.svh"

module mcu_rotate_subtract_skip_set_exec
#(
    parameter int unsigned CYCLE_DIV = `INSTR_CYCLE_CLOCKS  // Clocks per instruction cycle
)
(
    input  wire logic             ref_clk,      // 125 MHz core clock
    input  wire logic             rst,          // Async reset, active high
    input  wire logic [3:0]       address,      // Avalon byte address
    input  wire logic             read,         // Avalon read
    input  wire logic             write,        // Avalon write
    input  wire logic [31:0]      writedata,    // Avalon write data
    input  wire logic [3:0]       byteenable,   // Avalon byte enables
    output logic      [31:0]      readdata,     // Avalon read data
    output logic                  waitrequest,  // Avalon stall
    input  wire logic             opStart,      // Decoder offers an operation
    input  wire exec_pkg::op_t    opCode,       // Operation to run
    input  wire logic [7:0]       memRdData,    // Addressed memory byte
    input  wire logic [2:0]       bitSel,       // Bit position for single-bit set
    output logic                  opReady,      // Operation taken when high with opStart
    output logic                  memWrEn,      // One-cycle memory write strobe
    output logic      [7:0]       memWrData,    // Memory write data
    output logic                  skipReq,      // One-cycle skip-next request
    output logic                  opDone,       // One-cycle completion pulse
    output logic      [7:0]       workOut,      // Working register
    output logic      [3:0]       flagsOut      // Status flags
);
    import exec_pkg::*;

    localparam int CNT_W = $clog2(CYCLE_DIV + 1);

    state_t           state;
    state_t           next_state;
    op_t              opq;
    op_t              next_opq;
    logic [7:0]       operand;
    logic [7:0]       next_operand;
    logic [2:0]       bitq;
    logic [2:0]       next_bitq;
    logic [7:0]       work;
    logic [7:0]       next_work;
    logic [3:0]       flags;
    logic [3:0]       next_flags;
    logic             next_memWrEn;
    logic [7:0]       next_memWrData;
    logic             next_skipReq;
    logic             next_opDone;
    logic             decZero;
    logic             next_decZero;
    logic             lastSkip;
    logic             next_lastSkip;
    logic [CNT_W-1:0] cycCnt;
    logic [CNT_W-1:0] next_cycCnt;
    logic             cycEn;
    logic             execFire;
    logic             dummyFire;
    logic [7:0]       decValue;
    logic [7:0]       subRes;
    logic             subCarry;
    logic             subHalf;
    logic             subZero;
    logic             subRange;
    logic             ctrlEnable;
    logic             workWr;
    logic             flagsWr;
    logic [7:0]       wrByte;

    // Register slave; software can load work and flags, execution wins a tie
    avalon_regs u_regs
    (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .address     (address),
        .read        (read),
        .write       (write),
        .writedata   (writedata),
        .byteenable  (byteenable),
        .readdata    (readdata),
        .waitrequest (waitrequest),
        .work        (work),
        .flags       (flags),
        .busy        (state != ST_IDLE),
        .lastSkip    (lastSkip),
        .ctrlEnable  (ctrlEnable),
        .workWr      (workWr),
        .flagsWr     (flagsWr),
        .wrByte      (wrByte)
    );

    // Shared subtractor for both borrow forms
    sub_borrow_unit u_sub
    (
        .minuend    (work),
        .subtrahend (operand),
        .carryIn    (flags[`FLAG_CARRY_BIT]),
        .result     (subRes),
        .carryOut   (subCarry),
        .halfOut    (subHalf),
        .zeroOut    (subZero),
        .rangeOut   (subRange)
    );

    // Instruction-cycle enable from a free-running divider
    always_comb
    begin
        cycEn       = (cycCnt == CNT_W'(CYCLE_DIV - 1));
        next_cycCnt = cycEn ? '0 : cycCnt + CNT_W'(1);
    end

    assign execFire  = (state == ST_EXEC) && cycEn;
    assign dummyFire = (state == ST_DUMMY) && cycEn;
    assign decValue  = operand - `DEC_STEP;
    assign opReady   = (state == ST_IDLE) && ctrlEnable;
    assign workOut   = work;
    assign flagsOut  = flags;

    // Sequencer and datapath next values
    always_comb
    begin
        next_state     = state;
        next_opq       = opq;
        next_operand   = operand;
        next_bitq      = bitq;
        next_work      = work;
        next_flags     = flags;
        next_memWrEn   = 1'b0;
        next_memWrData = memWrData;
        next_skipReq   = 1'b0;
        next_opDone    = 1'b0;
        next_decZero   = decZero;
        next_lastSkip  = lastSkip;
        // Software loads first so that an executing write overrides it
        if (workWr)
            next_work = wrByte;
        if (flagsWr)
            next_flags = wrByte[3:0];
        case (state)
            ST_IDLE:
            begin
                // Operand captured at acceptance; decoder may move on afterwards
                if (opStart && opReady)
                begin
                    next_opq     = opCode;
                    next_operand = memRdData;
                    next_bitq    = bitSel;
                    next_state   = ST_EXEC;
                end
            end
            ST_EXEC:
            begin
                if (cycEn)
                begin
                    next_state  = ST_IDLE;
                    next_opDone = 1'b1;
                    case (opq)
                        OP_ROTATE_CARRY_W:
                        begin
                            next_work = {flags[`FLAG_CARRY_BIT], operand[7:1]};
                            next_flags[`FLAG_CARRY_BIT] = operand[0];
                        end
                        OP_SUB_BORROW_W, OP_SUB_BORROW_M:
                        begin
                            if (opq == OP_SUB_BORROW_W)
                                next_work = subRes;
                            else
                            begin
                                next_memWrEn   = 1'b1;
                                next_memWrData = subRes;
                            end
                            next_flags[`FLAG_CARRY_BIT] = subCarry;
                            next_flags[`FLAG_HALF_BIT]  = subHalf;
                            next_flags[`FLAG_ZERO_BIT]  = subZero;
                            next_flags[`FLAG_RANGE_BIT] = subRange;
                        end
                        OP_DEC_SKIP_M, OP_DEC_SKIP_W:
                        begin
                            // Skip decision waits for the dummy cycle
                            if (opq == OP_DEC_SKIP_M)
                            begin
                                next_memWrEn   = 1'b1;
                                next_memWrData = decValue;
                            end
                            else
                                next_work = decValue;
                            next_decZero = (decValue == `BYTE_ZERO);
                            next_opDone  = 1'b0;
                            next_state   = ST_DUMMY;
                        end
                        OP_SET_BYTE:
                        begin
                            next_memWrEn   = 1'b1;
                            next_memWrData = `ALL_ONES;
                        end
                        OP_SET_BIT:
                        begin
                            next_memWrEn   = 1'b1;
                            next_memWrData = operand | (`SINGLE_BIT << bitq);
                        end
                        default:
                        begin
                            next_opDone = 1'b1;
                        end
                    endcase
                end
            end
            ST_DUMMY:
            begin
                // Second instruction cycle; flags are never touched here
                if (cycEn)
                begin
                    next_skipReq  = decZero;
                    next_lastSkip = decZero;
                    next_opDone   = 1'b1;
                    next_state    = ST_IDLE;
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Register stage
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state     <= ST_IDLE;
            opq       <= OP_ROTATE_CARRY_W;
            operand   <= `BYTE_ZERO;
            bitq      <= 3'h0;
            work      <= `WORK_RESET_VAL;
            flags     <= `FLAGS_RESET_VAL;
            memWrEn   <= 1'b0;
            memWrData <= `BYTE_ZERO;
            skipReq   <= 1'b0;
            opDone    <= 1'b0;
            decZero   <= 1'b0;
            lastSkip  <= 1'b0;
            cycCnt    <= '0;
        end
        else
        begin
            state     <= next_state;
            opq       <= next_opq;
            operand   <= next_operand;
            bitq      <= next_bitq;
            work      <= next_work;
            flags     <= next_flags;
            memWrEn   <= next_memWrEn;
            memWrData <= next_memWrData;
            skipReq   <= next_skipReq;
            opDone    <= next_opDone;
            decZero   <= next_decZero;
            lastSkip  <= next_lastSkip;
            cycCnt    <= next_cycCnt;
        end
    end

    // Checks on the executed results
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    AST_ROTATE_RESULT: assert property (
        execFire && opq == OP_ROTATE_CARRY_W |=>
            work == {$past(flags[`FLAG_CARRY_BIT]), $past(operand[7:1])}
            && flags[`FLAG_CARRY_BIT] == $past(operand[0]))
        else $error("rotate through carry result wrong");

    AST_ROTATE_ONLY_CARRY: assert property (
        execFire && opq == OP_ROTATE_CARRY_W && !flagsWr |=>
            !memWrEn && flags[3:1] == $past(flags[3:1]))
        else $error("rotate touched memory or other flags");

    AST_SUB_TO_WORK: assert property (
        execFire && opq == OP_SUB_BORROW_W |=>
            work == $past(subRes) && !memWrEn
            && flags[`FLAG_ZERO_BIT] == ($past(subRes) == `BYTE_ZERO))
        else $error("subtract to work result wrong");

    AST_SUB_CARRY: assert property (
        execFire && (opq == OP_SUB_BORROW_W || opq == OP_SUB_BORROW_M) |=>
            flags[`FLAG_CARRY_BIT] == ($past({1'b0, work}) >=
                ({1'b0, $past(operand)} + {8'h00, !$past(flags[`FLAG_CARRY_BIT])})))
        else $error("subtract carry wrong");

    AST_SUB_TO_MEM: assert property (
        execFire && opq == OP_SUB_BORROW_M && !workWr |=>
            memWrEn && memWrData == $past(subRes) && work == $past(work))
        else $error("subtract to memory result wrong");

    AST_DEC_SKIP: assert property (
        execFire && opq == OP_DEC_SKIP_M && decValue == `BYTE_ZERO |=>
            memWrEn && memWrData == `BYTE_ZERO ##[1:64] skipReq)
        else $error("decrement to zero gave no skip");

    AST_DEC_NO_SKIP: assert property (
        dummyFire && !decZero |=> !skipReq && opDone)
        else $error("skip raised on non-zero result");

    AST_DEC_TWO_CYCLES: assert property (
        execFire && (opq == OP_DEC_SKIP_M || opq == OP_DEC_SKIP_W) |=>
            state == ST_DUMMY && !opDone)
        else $error("decrement did not take a dummy cycle");

    AST_DEC_TO_WORK: assert property (
        execFire && opq == OP_DEC_SKIP_W |=>
            work == $past(decValue) && !memWrEn)
        else $error("decrement to work wrong");

    AST_SET_BYTE: assert property (
        execFire && opq == OP_SET_BYTE |=> memWrEn && memWrData == `ALL_ONES)
        else $error("whole byte set wrong");

    AST_SET_BIT: assert property (
        execFire && opq == OP_SET_BIT |=>
            memWrEn && memWrData == ($past(operand) | (`SINGLE_BIT << $past(bitq))))
        else $error("single bit set wrong");

    AST_FLAGS_KEPT: assert property (
        execFire && !flagsWr && (opq == OP_DEC_SKIP_M || opq == OP_DEC_SKIP_W
            || opq == OP_SET_BYTE || opq == OP_SET_BIT) |=> flags == $past(flags))
        else $error("flags changed by decrement or set");

    COV_ROTATE:   cover property (execFire && opq == OP_ROTATE_CARRY_W);
    COV_SUB_MEM:  cover property (execFire && opq == OP_SUB_BORROW_M);
    COV_SKIP:     cover property (skipReq);
    COV_SET_BIT:  cover property (execFire && opq == OP_SET_BIT && bitq == 3'h7);

endmodule

// ===== tb/mem_model.sv
`timescale 1ns/1ns

module mem_model
(
    input  wire logic       ref_clk,    // Core clock
    input  wire logic       rst,        // Async reset, active high
    input  wire logic       ld,         // Bench preloads the byte
    input  wire logic [7:0] ldVal,      // Preload value
    input  wire logic       memWrEn,    // Write strobe from the block
    input  wire logic [7:0] memWrData,  // Write data from the block
    output logic      [7:0] memRdData   // Addressed byte
);
    // One addressed byte; preload only happens between operations, so no clash
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            memRdData <= 8'h00;
        else if (memWrEn)
            memRdData <= memWrData;
        else if (ld)
            memRdData <= ldVal;
    end
endmodule

// ===== tb/mcu_rotate_subtract_skip_set_exec_tb.sv
`timescale 1ns/1ns

module mcu_rotate_subtract_skip_set_exec_tb;
    import exec_pkg::*;
    localparam int DIV = 2;
    logic                ref_clk;
    logic                rst;
    logic                read;
    logic                write;
    logic                opStart;
    logic                ld;
    logic                waitrequest;
    logic                opReady;
    logic                memWrEn;
    logic                skipReq;
    logic                opDone;
    logic         [3:0]  address;
    logic         [3:0]  byteenable;
    logic         [3:0]  flagsOut;
    logic         [31:0] writedata;
    logic         [31:0] readdata;
    logic         [31:0] rd;
    logic         [7:0]  memRdData;
    logic         [7:0]  memWrData;
    logic         [7:0]  workOut;
    logic         [7:0]  ldVal;
    logic         [2:0]  bitSel;
    op_t                 opCode;
    int                  n_mismatch;
    int                  num_checks;
    int                  ticks;
    int                  wrAt;
    int                  doneAt;
    int                  skips;

    mcu_rotate_subtract_skip_set_exec #(.CYCLE_DIV(DIV)) i_mcu_rotate_subtract_skip_set_exec
    (
        .ref_clk(ref_clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .opStart(opStart), .opCode(opCode),
        .memRdData(memRdData), .bitSel(bitSel), .opReady(opReady), .memWrEn(memWrEn),
        .memWrData(memWrData), .skipReq(skipReq), .opDone(opDone), .workOut(workOut),
        .flagsOut(flagsOut)
    );
    mem_model i_mem_model
    (
        .ref_clk(ref_clk), .rst(rst), .ld(ld), .ldVal(ldVal), .memWrEn(memWrEn),
        .memWrData(memWrData), .memRdData(memRdData)
    );

    // Free-running 125 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Hang guard, well above the few hundred cycles the sequence needs
    always @(posedge ref_clk)
    begin
        ticks <= ticks + 1;
        if (ticks == 20000)
        begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (n_mismatch == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Avalon access: hold everything until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        read      <= ~wr;
        write     <= wr;
        address   <= a;
        writedata <= d;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        rd = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    // Preload memory, offer one operation, then log strobes until completion
    task automatic op(input op_t c, input logic [7:0] m, input logic [2:0] b);
        @(posedge ref_clk);
        ld    <= 1'b1;
        ldVal <= m;
        @(posedge ref_clk);
        ld      <= 1'b0;
        opStart <= 1'b1;
        opCode  <= c;
        bitSel  <= b;
        do @(posedge ref_clk); while (opReady !== 1'b1);
        opStart <= 1'b0;
        wrAt   = -1;
        doneAt = 0;
        skips  = 0;
        repeat (40)
        begin
            @(posedge ref_clk);
            doneAt++;
            if (memWrEn === 1'b1) wrAt = doneAt;
            if (skipReq === 1'b1) skips++;
            if (opDone === 1'b1) break;
        end
        @(negedge ref_clk);
        chk(opDone === 1'b0 && doneAt < 40, 1);
    endtask

    initial
    begin
        rst = 1'b1; read = 1'b0; write = 1'b0; address = 4'h0; writedata = 32'h0;
        byteenable = 4'hF; opStart = 1'b0; opCode = OP_SET_BYTE; bitSel = 3'h0;
        ld = 1'b0; ldVal = 8'h00; n_mismatch = 0; num_checks = 0; ticks = 0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        // Reset values and an unmapped offset
        bus(1'b0, 4'h0, 32'h0); chk(rd, 32'h1);
        bus(1'b0, 4'h4, 32'h0); chk(rd, 32'h0);
        bus(1'b0, 4'h8, 32'h0); chk(rd, 32'h0);
        bus(1'b0, 4'h2, 32'h0); chk(rd, 32'h0);
        // Rotate through carry, other flags set to catch stray updates
        bus(1'b1, 4'h8, 32'hE); op(OP_ROTATE_CARRY_W, 8'h81, 3'h0);
        chk(workOut, 8'h40);
        chk(flagsOut, 4'hF);
        chk(memRdData, 8'h81); chk(wrAt, -1);
        // Subtract with borrow into work: negative, then zero
        bus(1'b1, 4'h4, 32'h10); bus(1'b1, 4'h8, 32'h1); op(OP_SUB_BORROW_W, 8'h20, 3'h0);
        chk(workOut, 8'hF0); chk(flagsOut, 4'h2);
        bus(1'b1, 4'h4, 32'h5); bus(1'b1, 4'h8, 32'h1); op(OP_SUB_BORROW_W, 8'h05, 3'h0);
        chk(workOut, 8'h00); chk(flagsOut, 4'h7);
        // Subtract into memory with pending borrow and signed overflow
        bus(1'b1, 4'h4, 32'h80); bus(1'b1, 4'h8, 32'h0); op(OP_SUB_BORROW_M, 8'h00, 3'h0);
        chk(memRdData, 8'h7F); chk(workOut, 8'h80);
        chk(flagsOut, 4'h9);
        // Decrement in memory: reaches zero, then wraps
        bus(1'b1, 4'h8, 32'h5); op(OP_DEC_SKIP_M, 8'h01, 3'h0);
        chk(memRdData, 8'h00); chk(skips, 1);
        chk(doneAt - wrAt, DIV); chk(flagsOut, 4'h5);
        bus(1'b0, 4'hC, 32'h0); chk(rd, 32'h2);
        op(OP_DEC_SKIP_M, 8'h00, 3'h0);
        chk(memRdData, 8'hFF); chk(skips, 0); chk(flagsOut, 4'h5);
        bus(1'b0, 4'hC, 32'h0); chk(rd, 32'h0);
        // Decrement into work, memory left alone
        op(OP_DEC_SKIP_W, 8'h01, 3'h0);
        chk(workOut, 8'h00); chk(memRdData, 8'h01); chk(skips, 1);
        chk(wrAt, -1);
        op(OP_DEC_SKIP_W, 8'h03, 3'h0);
        chk(workOut, 8'h02); chk(skips, 0); chk(flagsOut, 4'h5);
        // Whole-byte and every single-bit set
        op(OP_SET_BYTE, 8'h12, 3'h0);
        chk(memRdData, 8'hFF); chk(flagsOut, 4'h5);
        for (int i = 0; i < 8; i++)
        begin
            op(OP_SET_BIT, 8'h5A, i[2:0]);
            chk(memRdData, 8'h5A | (8'h01 << i)); chk(flagsOut, 4'h5);
        end
        // Write with lane 0 disabled is dropped; work still holds the last decrement
        bus(1'b0, 4'h4, 32'h0); byteenable <= 4'hE; bus(1'b1, 4'h4, 32'hAA);
        byteenable <= 4'hF; bus(1'b0, 4'h4, 32'h0); chk(rd, 32'h2);
        // Disabled acceptance blocks new operations
        bus(1'b1, 4'h0, 32'h0); @(negedge ref_clk); chk(opReady, 1'b0);
        bus(1'b1, 4'h0, 32'h1); @(negedge ref_clk); chk(opReady, 1'b1);
        complete_run();
    end
endmodule
